// ===== pmc_regs.vh
// constants of the power-management enable and reset control block
// assumes inclusion by bare name from the design files; definitions only
`ifndef PMC_REGS_VH
`define PMC_REGS_VH

// rail positions in the rail status vector and the number of rails
`define PMC_RAIL_CORE 0
`define PMC_RAIL_SYS 1
`define PMC_RAIL_MEM 2
`define PMC_RAIL_LRA 3
`define PMC_RAIL_LRB 4
`define PMC_NRAILS 5

// timing: figures as specified, in their own units
`define PMC_MCLK_KHZ 125000
`define PMC_DEBOUNCE_MS 30
`define PMC_HOLD_MS 100
`define PMC_SYNC_SETTLE 3'h4

// voltage setting width and default output voltages in millivolts
`define PMC_MV_W 12
`define PMC_CORE_LO_MV 12'h4b0
`define PMC_CORE_HI_MV 12'h640
`define PMC_SYSMEM_LO_MV 12'h708
`define PMC_SYSMEM_HI_MV 12'hce4
`define PMC_LR_1V3_MV 12'h514
`define PMC_LR_1V8_MV 12'h708
`define PMC_LR_2V8_MV 12'haf0
`define PMC_LR_3V3_MV 12'hce4

// reset values
`define PMC_RST_MV 12'h000
`define PMC_RST_EN 1'b0

`endif

// ===== pmc_debounce.v
// level filter: output follows the input only after it stays stable
// assumes the input is already synchronised to mclk
`timescale 1ns/100ps
`include "pmc_regs.vh"

module pmc_debounce #(
    parameter CNT_W = 24,
    parameter [CNT_W-1:0] FILT_CYC = 24'd3750000
) (
    // clock and reset
    input wire mclk,
    input wire rst,
    // level in and filtered level out
    input wire lvl_in,
    output reg lvl_out
);

    reg [CNT_W-1:0] cnt_ff;

    // restart the count whenever the input matches the output, accept after full count
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_ff <= {CNT_W{1'b0}};
            lvl_out <= 1'b0;
        end else if (lvl_in == lvl_out) begin
            cnt_ff <= {CNT_W{1'b0}};
        end else if (cnt_ff >= FILT_CYC - 1'b1) begin
            cnt_ff <= {CNT_W{1'b0}};
            lvl_out <= lvl_in;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

endmodule

// ===== pmc_enable_reset_control.v
// enable, power-good and processor reset control of a multi-rail supply
// assumes analog comparators hand in level indications (with their own
// hysteresis) on pins, and control settings arrive from logic on mclk
//
// Function
// - each converter follows its own enable pin: low off, high on
// - one common pin enables both linear regulators; settings may switch either off
// - discharge off after reset; per-converter bit applies it while converter disabled
// - per-rail status shows fault below target margin, clears after recovery
// - interrupt raised when any monitored rail with its mask bit clear enters fault
// - disabled rail reports good and never faults or interrupts
// - undervoltage lockout forces every converter and regulator off
// - overtemperature powers every converter and regulator down
// - active warm restart pulls the processor reset low
// - warm restart restores only the core voltage to strap default
// - warm restart input is debounced about thirty milliseconds
// - reset held low while backup rail bad, then for hold time
// - processor reset is open drain: pulls low or releases
// - core voltage returns to default on restart, backup low, lockout, reset
// - power-fail and battery-low flags follow their sense comparators
// - linear regulator select straps latched once at power-up
// - linear regulator voltages remain writable after power-up
// - core default 1.2 V strap low, 1.6 V strap high
// - system and memory converters default 1.8 V low, 3.3 V high
// - interrupt low in power-up and on unmasked fault, high on recovery
// - status read while interrupt low releases it; fault bit stays
`timescale 1ns/100ps
`include "pmc_regs.vh"

module pmc_enable_reset_control #(
    parameter CNT_W = 24,
    parameter [CNT_W-1:0] DEBOUNCE_CYC = `PMC_DEBOUNCE_MS * `PMC_MCLK_KHZ,
    parameter [CNT_W-1:0] RESET_HOLD_CYC = `PMC_HOLD_MS * `PMC_MCLK_KHZ
) (
    // clock and reset
    input wire mclk,
    input wire rst,
    // enable pins
    input wire core_conv_on,
    input wire sys_conv_on,
    input wire mem_conv_on,
    input wire linreg_pair_on,
    // analog indications
    input wire uvlo_active,
    input wire thermal_trip,
    input wire backup_rail_good,
    input wire [`PMC_NRAILS-1:0] rail_low,
    input wire power_fail_sense_low,
    input wire battery_low_sense_low,
    // warm restart pin
    input wire warm_restart_in,
    // strap pins
    input wire core_default_sel,
    input wire sys_default_sel,
    input wire mem_default_sel,
    input wire linreg_sel_lo,
    input wire linreg_sel_hi,
    // control settings from local logic
    input wire [2:0] discharge_sel,
    input wire linreg_a_off,
    input wire linreg_b_off,
    input wire linreg_cfg_wr,
    input wire [`PMC_MV_W-1:0] linreg_a_mv_wdata,
    input wire [`PMC_MV_W-1:0] linreg_b_mv_wdata,
    input wire core_mv_wr,
    input wire [`PMC_MV_W-1:0] core_mv_wdata,
    input wire [`PMC_NRAILS-1:0] fault_mask,
    input wire status_rd,
    // rail enables and discharge
    output reg [2:0] conv_en,
    output reg [1:0] linreg_en,
    output reg [2:0] discharge_on,
    // voltage settings and strap latch flag
    output reg [`PMC_MV_W-1:0] core_mv,
    output reg [`PMC_MV_W-1:0] sys_mv,
    output reg [`PMC_MV_W-1:0] mem_mv,
    output reg [`PMC_MV_W-1:0] linreg_a_mv,
    output reg [`PMC_MV_W-1:0] linreg_b_mv,
    output reg straps_valid,
    // status
    output reg [`PMC_NRAILS-1:0] rail_fault_flags,
    output reg power_fail_flag,
    output reg battery_low_flag,
    // open-drain interrupt and processor reset
    output reg irq_o,
    output reg irq_oe_n,
    output reg cpu_reset_n_o,
    output reg cpu_reset_n_oe_n
);

    localparam NP = 20;

    // strap code to first/second linear regulator millivolts
    function [2*`PMC_MV_W-1:0] lr_default;
        input [1:0] code;
        begin
            case (code)
                2'h0: lr_default = {`PMC_LR_1V3_MV, `PMC_LR_3V3_MV};
                2'h1: lr_default = {`PMC_LR_2V8_MV, `PMC_LR_3V3_MV};
                2'h2: lr_default = {`PMC_LR_1V3_MV, `PMC_LR_1V8_MV};
                default: lr_default = {`PMC_LR_3V3_MV, `PMC_LR_1V8_MV};
            endcase
        end
    endfunction

    wire [NP-1:0] pin_raw;
    reg [NP-1:0] s1_ff;
    reg [NP-1:0] s2_ff;
    reg [NP-1:0] s3_ff;
    reg [NP-1:0] pin_ff;
    reg [2:0] settle_ff;
    reg core_strap_ff;
    reg [`PMC_NRAILS-1:0] fault_prev_ff;
    reg release_ff;
    reg [CNT_W-1:0] hold_cnt_ff;
    reg hold_done_ff;
    wire warm_active;
    wire [2:0] conv_pin;
    wire lr_pin;
    wire uvlo_s;
    wire therm_s;
    wire backup_s;
    wire [`PMC_NRAILS-1:0] low_s;
    wire [4:0] strap_s;
    wire force_off;
    wire [`PMC_NRAILS-1:0] rail_on;
    wire [`PMC_NRAILS-1:0] fault_now;
    wire [`PMC_NRAILS-1:0] unmasked;
    wire irq_cond;
    wire new_fault;
    wire reset_hold;
    wire core_to_default;
    wire [`PMC_MV_W-1:0] core_dflt;
    reg [2:0] nxt_conv_en;
    reg [1:0] nxt_linreg_en;

    assign pin_raw = {linreg_sel_hi, linreg_sel_lo, mem_default_sel, sys_default_sel,
                      core_default_sel, warm_restart_in, battery_low_sense_low,
                      power_fail_sense_low, rail_low, backup_rail_good, thermal_trip,
                      uvlo_active, linreg_pair_on, mem_conv_on, sys_conv_on, core_conv_on};

    // three-stage synchroniser; a change counts once stages two and three agree
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_ff <= {NP{1'b0}};
            s2_ff <= {NP{1'b0}};
            s3_ff <= {NP{1'b0}};
            pin_ff <= {NP{1'b0}};
        end else begin
            s1_ff <= pin_raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            pin_ff <= (s2_ff & s3_ff) | (pin_ff & (s2_ff ^ s3_ff));
        end
    end

    assign conv_pin = pin_ff[2:0];
    assign lr_pin = pin_ff[3];
    assign uvlo_s = pin_ff[4];
    assign therm_s = pin_ff[5];
    assign backup_s = pin_ff[6];
    assign low_s = pin_ff[11:7];
    assign strap_s = pin_ff[19:15];

    // warm restart must hold steady for the full filter time
    pmc_debounce #(
        .CNT_W(CNT_W),
        .FILT_CYC(DEBOUNCE_CYC)
    ) u_warm_filt (
        .mclk(mclk),
        .rst(rst),
        .lvl_in(pin_ff[14]),
        .lvl_out(warm_active)
    );

    // straps are sampled once the synchroniser has settled after power-up
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            settle_ff <= 3'h0; // filtered straps are valid only after the fourth edge
            straps_valid <= 1'b0;
            core_strap_ff <= 1'b0;
            sys_mv <= `PMC_RST_MV;
            mem_mv <= `PMC_RST_MV;
        end else if (!straps_valid) begin
            if (settle_ff == `PMC_SYNC_SETTLE) begin
                straps_valid <= 1'b1;
                core_strap_ff <= strap_s[0];
                sys_mv <= strap_s[1] ? `PMC_SYSMEM_HI_MV : `PMC_SYSMEM_LO_MV;
                mem_mv <= strap_s[2] ? `PMC_SYSMEM_HI_MV : `PMC_SYSMEM_LO_MV;
            end else begin
                settle_ff <= settle_ff + 1'b1;
            end
        end
    end

    // lockout and overtemperature dominate every enable
    assign force_off = uvlo_s | therm_s | ~straps_valid;

    always @* begin
        nxt_conv_en = conv_pin & {3{~force_off}};
        nxt_linreg_en = {~linreg_b_off, ~linreg_a_off} & {2{lr_pin & ~force_off}};
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            conv_en <= {3{`PMC_RST_EN}};
            linreg_en <= {2{`PMC_RST_EN}};
            discharge_on <= 3'h0;
        end else begin
            conv_en <= nxt_conv_en;
            linreg_en <= nxt_linreg_en;
            discharge_on <= discharge_sel & ~nxt_conv_en;
        end
    end

    // linear regulator voltages: strap defaults, then writable at run time
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            linreg_a_mv <= `PMC_RST_MV;
            linreg_b_mv <= `PMC_RST_MV;
        end else if (!straps_valid) begin
            if (settle_ff == `PMC_SYNC_SETTLE) begin
                {linreg_a_mv, linreg_b_mv} <= lr_default(strap_s[4:3]);
            end
        end else if (linreg_cfg_wr) begin
            linreg_a_mv <= linreg_a_mv_wdata;
            linreg_b_mv <= linreg_b_mv_wdata;
        end
    end

    // processor reset hold counter restarts whenever backup rail drops
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            hold_cnt_ff <= {CNT_W{1'b0}};
            hold_done_ff <= 1'b0;
        end else if (!backup_s) begin
            hold_cnt_ff <= {CNT_W{1'b0}};
            hold_done_ff <= 1'b0;
        end else if (!hold_done_ff) begin
            if (hold_cnt_ff >= RESET_HOLD_CYC - 1'b1) begin
                hold_done_ff <= 1'b1;
            end else begin
                hold_cnt_ff <= hold_cnt_ff + 1'b1;
            end
        end
    end

    assign reset_hold = ~hold_done_ff | warm_active;

    // open drain: value always low, only the enable moves
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cpu_reset_n_o <= 1'b0;
            cpu_reset_n_oe_n <= 1'b0;
        end else begin
            cpu_reset_n_o <= 1'b0;
            cpu_reset_n_oe_n <= ~reset_hold;
        end
    end

    // core voltage: default under any of the restore causes, else writes
    assign core_dflt = core_strap_ff ? `PMC_CORE_HI_MV : `PMC_CORE_LO_MV;
    assign core_to_default = warm_active | ~backup_s | uvlo_s | ~cpu_reset_n_oe_n
                             | ~straps_valid;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            core_mv <= `PMC_RST_MV;
        end else if (!straps_valid) begin
            if (settle_ff == `PMC_SYNC_SETTLE) begin
                core_mv <= strap_s[0] ? `PMC_CORE_HI_MV : `PMC_CORE_LO_MV;
            end
        end else if (core_to_default) begin
            core_mv <= core_dflt;
        end else if (core_mv_wr) begin
            core_mv <= core_mv_wdata;
        end
    end

    // monitors only look at enabled rails; disabled rails read good
    assign rail_on = {linreg_en, conv_en};
    assign fault_now = low_s & rail_on;
    assign unmasked = fault_now & ~fault_mask;
    // no rail enabled also holds the line low, whatever the mask
    assign irq_cond = (|unmasked) | ~(|rail_on);
    assign new_fault = |(unmasked & ~fault_prev_ff);

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rail_fault_flags <= {`PMC_NRAILS{1'b0}};
            fault_prev_ff <= {`PMC_NRAILS{1'b0}};
            power_fail_flag <= 1'b0;
            battery_low_flag <= 1'b0;
        end else begin
            rail_fault_flags <= fault_now;
            fault_prev_ff <= unmasked;
            power_fail_flag <= pin_ff[12];
            battery_low_flag <= pin_ff[13];
        end
    end

    // a status read releases the line; a fresh fault wins over the read
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            release_ff <= 1'b0;
        end else if (new_fault || !irq_cond) begin
            release_ff <= 1'b0;
        end else if (status_rd && !irq_oe_n) begin
            release_ff <= 1'b1;
        end
    end

    // interrupt drives low while active and not released
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_o <= 1'b0;
            irq_oe_n <= 1'b0;
        end else begin
            irq_o <= 1'b0;
            irq_oe_n <= ~(irq_cond & (new_fault | ~release_ff));
        end
    end

endmodule

// ===== pmc_enable_reset_control_sva.sv
// assertions on the pins of the enable and reset control block
// assumes binding into pmc_enable_reset_control, one mclk domain
`timescale 1ns/100ps
`include "pmc_regs.vh"
module pmc_erc_chk #(
    parameter CNT_W = 24,
    parameter [CNT_W-1:0] DEBOUNCE_CYC = `PMC_DEBOUNCE_MS * `PMC_MCLK_KHZ,
    parameter [CNT_W-1:0] RESET_HOLD_CYC = `PMC_HOLD_MS * `PMC_MCLK_KHZ
) (
    // clock and reset
    input wire mclk,
    input wire rst,
    // pins and settings
    input wire core_conv_on,
    input wire uvlo_active,
    input wire thermal_trip,
    input wire backup_rail_good,
    input wire warm_restart_in,
    input wire core_default_sel,
    input wire [2:0] discharge_sel,
    input wire [`PMC_NRAILS-1:0] fault_mask,
    input wire status_rd,
    // block outputs
    input wire [2:0] conv_en,
    input wire [1:0] linreg_en,
    input wire [2:0] discharge_on,
    input wire [`PMC_MV_W-1:0] core_mv,
    input wire straps_valid,
    input wire [`PMC_NRAILS-1:0] rail_fault_flags,
    input wire irq_o,
    input wire irq_oe_n,
    input wire cpu_reset_n_o,
    input wire cpu_reset_n_oe_n
);
    logic [CNT_W:0] warm_run_ff;
    logic [CNT_W:0] good_run_ff;
    // run lengths of pin levels; too long to express as repetitions
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            warm_run_ff <= '0;
            good_run_ff <= '0;
        end else begin
            warm_run_ff <= warm_restart_in ? warm_run_ff + 1'b1 : '0;
            good_run_ff <= backup_rail_good ? good_run_ff + 1'b1 : '0;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    AST_STRAP_GATE: assert property (!straps_valid |-> conv_en == 3'h0 && linreg_en == 2'h0)
        else $error("rail enabled before straps latched");
    AST_STRAP_HOLD: assert property (straps_valid |=> straps_valid)
        else $error("strap latch dropped");
    AST_CORE_OFF: assert property (!core_conv_on [*8] |-> !conv_en[0])
        else $error("core converter on with pin low");
    AST_UVLO_OFF: assert property (uvlo_active [*6] |=> {conv_en, linreg_en} == 5'h00)
        else $error("rail on during lockout");
    AST_HOT_OFF: assert property (thermal_trip [*6] |=> {conv_en, linreg_en} == 5'h00)
        else $error("rail on during overtemperature");
    AST_DISCH: assert property (discharge_on != 3'h0 |-> (discharge_on & conv_en) == 3'h0
        && (discharge_on & ~$past(discharge_sel)) == 3'h0)
        else $error("discharge on enabled or unselected converter");
    AST_GOOD_OFF: assert property ((rail_fault_flags & ~{linreg_en, conv_en}
        & ~$past({linreg_en, conv_en})) == 5'h00)
        else $error("fault shown on disabled rail");
    AST_FAULT_IRQ: assert property ($rose(|(rail_fault_flags & ~fault_mask))
        |-> ##[0:1] !irq_oe_n)
        else $error("unmasked fault without interrupt");
    AST_READ_REL: assert property (status_rd && !irq_oe_n && {linreg_en, conv_en} != 5'h00
        ##1 ($stable(rail_fault_flags) && $stable(conv_en)) [*3] |-> irq_oe_n)
        else $error("status read did not release interrupt");
    AST_HOLD: assert property ($rose(cpu_reset_n_oe_n) |-> good_run_ff >= RESET_HOLD_CYC)
        else $error("processor reset released before hold time");
    AST_WARM: assert property (warm_run_ff > DEBOUNCE_CYC + 6 |-> !cpu_reset_n_oe_n)
        else $error("warm restart did not assert processor reset");
    AST_CORE_DEF: assert property ((!cpu_reset_n_oe_n && straps_valid) [*3]
        |-> core_mv == (core_default_sel ? `PMC_CORE_HI_MV : `PMC_CORE_LO_MV))
        else $error("core setting not at default during reset");
    AST_OPEN_DRAIN: assert property (cpu_reset_n_o == 1'b0 && irq_o == 1'b0)
        else $error("open-drain line driven high");
    // main scenarios reached
    cover property ($rose(cpu_reset_n_oe_n));
    cover property ($fell(irq_oe_n));
    cover property (status_rd && !irq_oe_n);
endmodule
bind pmc_enable_reset_control pmc_erc_chk #(.CNT_W(CNT_W), .DEBOUNCE_CYC(DEBOUNCE_CYC),
    .RESET_HOLD_CYC(RESET_HOLD_CYC)) u_chk (.*);

// ===== pmc_host_model.sv
// processor side: pull-ups on the open-drain reset and interrupt lines
// assumes a line is pulled low only while its enable is low
`timescale 1ns/100ps
module pmc_host_model (
    // open-drain drivers of the block
    input wire logic cpu_reset_n_o,
    input wire logic cpu_reset_n_oe_n,
    input wire logic irq_o,
    input wire logic irq_oe_n,
    // levels seen by the processor
    output wire logic cpu_reset_n,
    output wire logic irq_n
);
    // a released line floats up to the resistor level
    assign cpu_reset_n = cpu_reset_n_oe_n ? 1'h1 : cpu_reset_n_o;
    assign irq_n = irq_oe_n ? 1'h1 : irq_o;
endmodule

// ===== pmc_enable_reset_control_tb.sv
// self-checking bench of the enable and reset control block
// assumes the design, checker and host model are compiled before it
`timescale 1ns/100ps
module pmc_enable_reset_control_tb;
    localparam DEB = 16;
    localparam HOLD = 20;
    localparam [47:0] LA = {12'hce4, 12'h514, 12'haf0, 12'h514};
    localparam [47:0] LB = {12'h708, 12'h708, 12'hce4, 12'hce4};
    reg mclk = 1'h0, rst = 1'h1;
    reg core_conv_on = 1'h0, sys_conv_on = 1'h0, mem_conv_on = 1'h0, linreg_pair_on = 1'h0;
    reg uvlo_active = 1'h0, thermal_trip = 1'h0, backup_rail_good = 1'h0, warm_restart_in = 1'h0;
    reg [4:0] rail_low = 5'h00, fault_mask = 5'h02;
    reg power_fail_sense_low = 1'h0, battery_low_sense_low = 1'h0, status_rd = 1'h0;
    reg core_default_sel, sys_default_sel, mem_default_sel, linreg_sel_lo, linreg_sel_hi;
    reg [2:0] discharge_sel = 3'h7;
    reg linreg_a_off = 1'h0, linreg_b_off = 1'h1, linreg_cfg_wr = 1'h0, core_mv_wr = 1'h0;
    reg [11:0] linreg_a_mv_wdata = 12'h5dc, linreg_b_mv_wdata = 12'h4b0, core_mv_wdata = 12'h3e8;
    wire [2:0] conv_en, discharge_on;
    wire [1:0] linreg_en;
    wire [11:0] core_mv, sys_mv, mem_mv, linreg_a_mv, linreg_b_mv;
    wire [4:0] rail_fault_flags;
    wire straps_valid, power_fail_flag, battery_low_flag, irq_o, irq_oe_n;
    wire cpu_reset_n_o, cpu_reset_n_oe_n, cpu_reset_n, irq_n;
    integer num_errors = 0;
    integer n_tests = 0;
    integer i;
    integer n;
    pmc_enable_reset_control #(.DEBOUNCE_CYC(DEB), .RESET_HOLD_CYC(HOLD)) dut (.*);
    pmc_host_model host (.*);
    always #4 mclk = ~mclk;
    // inputs move 1 ns after the edge, away from sampling
    task cyc(input integer k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task chk(input [11:0] got, input [11:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_sim;
        if (num_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        // one reset per strap code; backup low keeps the processor in reset
        for (i = 0; i < 4; i = i + 1) begin
            rst = 1'h1;
            {linreg_sel_hi, linreg_sel_lo} = i[1:0];
            core_default_sel = i[0];
            sys_default_sel = i[1];
            mem_default_sel = ~i[0];
            cyc(2);
            rst = 1'h0;
            cyc(8);
            chk(straps_valid, 12'h1);
            chk(linreg_a_mv, LA[i*12 +: 12]);
            chk(linreg_b_mv, LB[i*12 +: 12]);
            chk(core_mv, i[0] ? 12'h640 : 12'h4b0);
            chk(sys_mv, i[1] ? 12'hce4 : 12'h708);
            chk(mem_mv, i[0] ? 12'h708 : 12'hce4);
            chk(cpu_reset_n, 12'h0);
        end
        // hold time counted from the backup rail turning good
        backup_rail_good = 1'h1;
        n = 0;
        while (cpu_reset_n !== 1'h1 && n < 200) begin
            cyc(1);
            n = n + 1;
        end
        if (n == 200) begin
            num_errors = num_errors + 1;
            end_sim;
        end
        chk(n[11:0], 12'd25);
        {mem_conv_on, sys_conv_on, core_conv_on} = 3'h3;
        linreg_pair_on = 1'h1;
        cyc(6);
        chk(conv_en, 12'h3);
        chk(linreg_en, 12'h1);
        chk(discharge_on, 12'h4);
        chk(irq_n, 12'h1);
        // masked fault first, then unmask; the disabled memory rail stays good
        rail_low = 5'h06;
        cyc(6);
        chk(rail_fault_flags, 12'h02);
        chk(irq_n, 12'h1);
        fault_mask = 5'h00;
        cyc(2);
        chk(irq_n, 12'h0);
        status_rd = 1'h1;
        cyc(1);
        status_rd = 1'h0;
        cyc(4);
        chk(irq_n, 12'h1);
        chk(rail_fault_flags, 12'h02);
        rail_low = 5'h00;
        cyc(6);
        chk(rail_fault_flags, 12'h00);
        linreg_cfg_wr = 1'h1;
        core_mv_wr = 1'h1;
        cyc(1);
        linreg_cfg_wr = 1'h0;
        core_mv_wr = 1'h0;
        cyc(1);
        chk(linreg_a_mv, 12'h5dc);
        chk(linreg_b_mv, 12'h4b0);
        chk(core_mv, 12'h3e8);
        // a pulse shorter than the filter is ignored, a long one resets
        warm_restart_in = 1'h1;
        cyc(DEB - 4);
        warm_restart_in = 1'h0;
        cyc(DEB + 8);
        chk(cpu_reset_n, 12'h1);
        warm_restart_in = 1'h1;
        cyc(DEB + 8);
        chk(cpu_reset_n, 12'h0);
        chk(core_mv, 12'h640);
        chk(linreg_a_mv, 12'h5dc);
        warm_restart_in = 1'h0;
        cyc(DEB + 8);
        chk(cpu_reset_n, 12'h1);
        core_mv_wdata = 12'h44c;
        core_mv_wr = 1'h1;
        cyc(1);
        core_mv_wr = 1'h0;
        cyc(1);
        chk(core_mv, 12'h44c);
        uvlo_active = 1'h1;
        cyc(7);
        chk({conv_en, linreg_en}, 12'h00);
        chk(discharge_on, 12'h7);
        chk(core_mv, 12'h640);
        uvlo_active = 1'h0;
        thermal_trip = 1'h1;
        cyc(7);
        chk({conv_en, linreg_en}, 12'h00);
        thermal_trip = 1'h0;
        power_fail_sense_low = 1'h1;
        battery_low_sense_low = 1'h1;
        cyc(7);
        chk({power_fail_flag, battery_low_flag}, 12'h3);
        chk(conv_en, 12'h3);
        // settings switch each linear regulator off on its own
        linreg_a_off = 1'h1;
        linreg_b_off = 1'h0;
        cyc(2);
        chk(linreg_en, 12'h2);
        backup_rail_good = 1'h0;
        cyc(7);
        chk(cpu_reset_n, 12'h0);
        end_sim;
    end
endmodule
